// *** move_cmp_pkg.sv ***
// Contract
// - condition false: no transfer, compare, destination or flag change
// - bit move: designator low digits pick source bit, high digits dest
// - non-BCD designator or bit number above 15 flags error, skips move
// - digit move copies up to four digits, wrapping past digit 3 to 0
// - any low designator digit above 3 flags error and skips the move
// - block start bits from two low control digits, count from two high
// - block transfer counts up to 255 bits, FF in the high byte
// - block transfer runs past bit 15 into bit 0 of the next word
// - source or destination range leaving its data area flags error
// - faulty indirect address flags error for every instruction here
// - compare result goes to flags at 25505, 25506 and 25507
package move_cmp_pkg;
  localparam int WORD_W = 16;
  localparam int APB_AW = 12;
  // -------------------------------------------------------------------
  // opcodes and operand fields
  // -------------------------------------------------------------------
  localparam logic [1:0] OP_BIT_MOVE = 2'h0;
  localparam logic [1:0] OP_DIGIT_MOVE = 2'h1;
  localparam logic [1:0] OP_BLOCK = 2'h2;
  localparam logic [1:0] OP_COMPARE = 2'h3;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [7:0] BIT_LAST = 8'h0F;
  localparam logic [7:0] TENS_WEIGHT = 8'h0A;
  localparam logic [3:0] DIGIT_LAST = 4'h3;
  localparam int DD_SRC_LSB = 0;
  localparam int DD_CNT_LSB = 4;
  localparam int DD_DST_LSB = 8;
  localparam int BLK_SRC_LSB = 0;
  localparam int BLK_DST_LSB = 4;
  localparam int BLK_CNT_LSB = 8;
  localparam int FLAG_ADDR_GR = 25505;
  localparam int FLAG_ADDR_EQ = 25506;
  localparam int FLAG_ADDR_LE = 25507;
  // -------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------
  localparam logic [APB_AW-1:0] REG_STATUS = 12'h000;
  localparam logic [APB_AW-1:0] REG_MASK = 12'h004;
  localparam logic [APB_AW-1:0] REG_FLAGS = 12'h008;
  localparam logic [APB_AW-1:0] REG_CTRL = 12'h00C;
  localparam int EV_W = 2;
  localparam int EV_DONE = 0;
  localparam int EV_ERROR = 1;
  localparam int FL_ERR = 0;
  localparam int FL_GR = 1;
  localparam int FL_EQ = 2;
  localparam int FL_LE = 3;
  localparam int FL_BUSY = 4;
  localparam int CTRL_ENABLE = 0;
  localparam logic CTRL_ENABLE_RST = 1'h1;
  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CHECK = 6'h02,
    ST_RD_SRC = 6'h04,
    ST_RD_DST = 6'h08,
    ST_WR = 6'h10,
    ST_FINISH = 6'h20
  } state_t;
  typedef struct packed {
    logic [1:0] op;
    logic cond;
    logic [WORD_W-1:0] a;
    logic [WORD_W-1:0] b;
    logic [WORD_W-1:0] dst;
    logic [WORD_W-1:0] src_last;
    logic [WORD_W-1:0] dst_last;
    logic fault;
  } instr_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [WORD_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mem_req_t;
endpackage : move_cmp_pkg

// *** move_cmp_unit.sv ***
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module move_cmp_unit (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // instruction from sequencer
  input wire logic instr_start,
  input wire move_cmp_pkg::instr_t instr,
  output logic instr_busy,
  output logic instr_done,
  // result flags
  output logic instruction_error_flag,
  output logic greater_flag,
  output logic equal_flag,
  output logic less_flag,
  // data memory
  output move_cmp_pkg::mem_req_t mem,
  input wire logic [move_cmp_pkg::WORD_W-1:0] mem_rdata,
  input wire logic mem_ack,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [move_cmp_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq
);
  localparam int W = move_cmp_pkg::WORD_W;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic bcd_ok(input logic [W-1:0] w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < W / 4; i++) begin
      if (w[i*4 +: 4] > move_cmp_pkg::BCD_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : bcd_ok

  function automatic logic [7:0] bcd2(input logic [7:0] d);
    return 8'(d[7:4] * move_cmp_pkg::TENS_WEIGHT) + {4'h0, d[3:0]};
  endfunction : bcd2

  function automatic logic [W-1:0] digit_move(input logic [W-1:0] s,
      input logic [W-1:0] d, input logic [W-1:0] dd);
    logic [W-1:0] r;
    logic [1:0] si;
    logic [1:0] di;
    r = d;
    si = 2'h0;
    di = 2'h0;
    for (int i = 0; i < 4; i++) begin
      si = 2'(dd[move_cmp_pkg::DD_SRC_LSB +: 2] + 2'(i));
      di = 2'(dd[move_cmp_pkg::DD_DST_LSB +: 2] + 2'(i));
      if (4'(i) <= dd[move_cmp_pkg::DD_CNT_LSB +: 4]) begin
        r[{di, 2'h0} +: 4] = s[{si, 2'h0} +: 4];
      end
    end
    return r;
  endfunction : digit_move

  // ---------------------------------------------------------------------
  // latched instruction and decode
  // ---------------------------------------------------------------------
  move_cmp_pkg::state_t state_ff;
  move_cmp_pkg::instr_t ins_ff;
  move_cmp_pkg::mem_req_t mem_ff;
  logic cond_ff, busy_ff, done_ff, err_ff, gr_ff, eq_ff, le_ff, ctrl_en_ff;
  logic [W-1:0] srcw_ff, sw_ff, dw_ff, wr_word, blk_word;
  logic [3:0] sbit_ff, dbit_ff;
  logic [7:0] cnt_ff, src_num, dst_num, blk_cnt;
  logic accept, bad_bit, bad_digit, bad_block, bad;
  logic [8:0] s_span, d_span;
  logic [W:0] s_end, d_end;

  assign accept = ce && instr_start && state_ff == move_cmp_pkg::ST_IDLE;
  assign src_num = bcd2(ins_ff.b[7:0]);
  assign dst_num = bcd2(ins_ff.b[15:8]);
  assign bad_bit = !bcd_ok(ins_ff.b) || src_num > move_cmp_pkg::BIT_LAST ||
                   dst_num > move_cmp_pkg::BIT_LAST;
  assign bad_digit =
    ins_ff.b[move_cmp_pkg::DD_SRC_LSB +: 4] > move_cmp_pkg::DIGIT_LAST ||
    ins_ff.b[move_cmp_pkg::DD_CNT_LSB +: 4] > move_cmp_pkg::DIGIT_LAST ||
    ins_ff.b[move_cmp_pkg::DD_DST_LSB +: 4] > move_cmp_pkg::DIGIT_LAST;
  assign blk_cnt = ins_ff.b[move_cmp_pkg::BLK_CNT_LSB +: 8];
  assign s_span = 9'({5'h0, ins_ff.b[move_cmp_pkg::BLK_SRC_LSB +: 4]} +
                  {1'h0, blk_cnt} - 9'h001);
  assign d_span = 9'({5'h0, ins_ff.b[move_cmp_pkg::BLK_DST_LSB +: 4]} +
                  {1'h0, blk_cnt} - 9'h001);
  assign s_end = {1'h0, ins_ff.a} + {12'h000, s_span[8:4]};
  assign d_end = {1'h0, ins_ff.dst} + {12'h000, d_span[8:4]};
  assign bad_block = blk_cnt != 8'h00 &&
                     (s_end > {1'h0, ins_ff.src_last} ||
                      d_end > {1'h0, ins_ff.dst_last});
  always_comb begin
    bad = ins_ff.fault;
    case (ins_ff.op)
      move_cmp_pkg::OP_BIT_MOVE: bad = bad || bad_bit;
      move_cmp_pkg::OP_DIGIT_MOVE: bad = bad || bad_digit;
      move_cmp_pkg::OP_BLOCK: bad = bad || bad_block;
      default: bad = bad;
    endcase
  end

  // new destination word from the word just read
  always_comb begin
    blk_word = mem_rdata;
    blk_word[dbit_ff] = srcw_ff[sbit_ff];
    wr_word = mem_rdata;
    case (ins_ff.op)
      move_cmp_pkg::OP_BIT_MOVE: wr_word[dst_num[3:0]] =
        ins_ff.a[src_num[3:0]];
      move_cmp_pkg::OP_DIGIT_MOVE: wr_word =
        digit_move(ins_ff.a, mem_rdata, ins_ff.b);
      move_cmp_pkg::OP_BLOCK: wr_word = blk_word;
      default: wr_word = mem_rdata;
    endcase
  end

  // ---------------------------------------------------------------------
  // sequencer and memory port
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= move_cmp_pkg::ST_IDLE;
      mem_ff <= '0;
      ins_ff <= '0;
      cond_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      srcw_ff <= '0;
      sw_ff <= '0;
      dw_ff <= '0;
      sbit_ff <= 4'h0;
      dbit_ff <= 4'h0;
      cnt_ff <= 8'h00;
    end else if (ce) begin
      done_ff <= state_ff == move_cmp_pkg::ST_FINISH;
      case (state_ff)
        move_cmp_pkg::ST_IDLE: begin
          if (accept) begin
            ins_ff <= instr;
            cond_ff <= instr.cond && ctrl_en_ff;
            busy_ff <= 1'b1;
            state_ff <= move_cmp_pkg::ST_CHECK;
          end
        end
        move_cmp_pkg::ST_CHECK: begin
          sw_ff <= ins_ff.a;
          dw_ff <= ins_ff.dst;
          sbit_ff <= ins_ff.b[move_cmp_pkg::BLK_SRC_LSB +: 4];
          dbit_ff <= ins_ff.b[move_cmp_pkg::BLK_DST_LSB +: 4];
          cnt_ff <= blk_cnt;
          if (!cond_ff || bad) begin
            state_ff <= move_cmp_pkg::ST_FINISH;
          end else if (ins_ff.op == move_cmp_pkg::OP_COMPARE) begin
            state_ff <= move_cmp_pkg::ST_FINISH;
          end else if (ins_ff.op == move_cmp_pkg::OP_BLOCK) begin
            if (blk_cnt == 8'h00) begin
              state_ff <= move_cmp_pkg::ST_FINISH;
            end else begin
              mem_ff <= '{req: 1'b1, we: 1'b0, addr: ins_ff.a, wdata: '0};
              state_ff <= move_cmp_pkg::ST_RD_SRC;
            end
          end else begin
            mem_ff <= '{req: 1'b1, we: 1'b0, addr: ins_ff.dst, wdata: '0};
            state_ff <= move_cmp_pkg::ST_RD_DST;
          end
        end
        move_cmp_pkg::ST_RD_SRC: begin
          if (mem_ack) begin
            srcw_ff <= mem_rdata;
            mem_ff <= '{req: 1'b1, we: 1'b0, addr: dw_ff, wdata: '0};
            state_ff <= move_cmp_pkg::ST_RD_DST;
          end
        end
        move_cmp_pkg::ST_RD_DST: begin
          if (mem_ack) begin
            mem_ff <= '{req: 1'b1, we: 1'b1, addr: mem_ff.addr,
                        wdata: wr_word};
            state_ff <= move_cmp_pkg::ST_WR;
          end
        end
        move_cmp_pkg::ST_WR: begin
          if (mem_ack) begin
            mem_ff <= '0;
            if (ins_ff.op == move_cmp_pkg::OP_BLOCK && cnt_ff > 8'h01) begin
              sbit_ff <= 4'(sbit_ff + 4'h1);
              dbit_ff <= 4'(dbit_ff + 4'h1);
              if (sbit_ff == 4'hF) begin
                sw_ff <= W'(sw_ff + 1'b1);
              end
              if (dbit_ff == 4'hF) begin
                dw_ff <= W'(dw_ff + 1'b1);
              end
              cnt_ff <= 8'(cnt_ff - 8'h01);
              mem_ff <= '{req: 1'b1, we: 1'b0,
                          addr: (sbit_ff == 4'hF) ? W'(sw_ff + 1'b1) : sw_ff,
                          wdata: '0};
              state_ff <= move_cmp_pkg::ST_RD_SRC;
            end else begin
              state_ff <= move_cmp_pkg::ST_FINISH;
            end
          end
        end
        move_cmp_pkg::ST_FINISH: begin
          busy_ff <= 1'b0;
          state_ff <= move_cmp_pkg::ST_IDLE;
        end
        default: state_ff <= move_cmp_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // error and compare flags
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_ff <= 1'b0;
      gr_ff <= 1'b0;
      eq_ff <= 1'b0;
      le_ff <= 1'b0;
    end else if (ce && state_ff == move_cmp_pkg::ST_FINISH && cond_ff) begin
      err_ff <= bad;
      if (ins_ff.op == move_cmp_pkg::OP_COMPARE && !bad) begin
        gr_ff <= ins_ff.a > ins_ff.b;
        eq_ff <= ins_ff.a == ins_ff.b;
        le_ff <= ins_ff.a < ins_ff.b;
      end
    end
  end

  // ---------------------------------------------------------------------
  // apb registers and interrupt
  // ---------------------------------------------------------------------
  logic [move_cmp_pkg::EV_W-1:0] status_ff, mask_ff, ev_set, ev_clr;
  logic [31:0] prdata_ff, rd_mux;
  logic pready_ff, pslverr_ff, irq_ff, apb_done, mapped;

  assign apb_done = psel && penable && pready_ff;
  assign mapped = paddr == move_cmp_pkg::REG_STATUS ||
                  paddr == move_cmp_pkg::REG_MASK ||
                  paddr == move_cmp_pkg::REG_FLAGS ||
                  paddr == move_cmp_pkg::REG_CTRL;
  always_comb begin
    ev_set = '0;
    if (state_ff == move_cmp_pkg::ST_FINISH) begin
      ev_set[move_cmp_pkg::EV_DONE] = 1'b1;
      ev_set[move_cmp_pkg::EV_ERROR] = cond_ff && bad;
    end
    // clear only the bits that the read reported
    ev_clr = '0;
    if (apb_done && !pwrite && paddr == move_cmp_pkg::REG_STATUS) begin
      ev_clr = prdata_ff[move_cmp_pkg::EV_W-1:0];
    end
    rd_mux = 32'h0000_0000;
    case (paddr)
      move_cmp_pkg::REG_STATUS: rd_mux[move_cmp_pkg::EV_W-1:0] = status_ff;
      move_cmp_pkg::REG_MASK: rd_mux[move_cmp_pkg::EV_W-1:0] = mask_ff;
      move_cmp_pkg::REG_FLAGS: begin
        rd_mux[move_cmp_pkg::FL_ERR] = err_ff;
        rd_mux[move_cmp_pkg::FL_GR] = gr_ff;
        rd_mux[move_cmp_pkg::FL_EQ] = eq_ff;
        rd_mux[move_cmp_pkg::FL_LE] = le_ff;
        rd_mux[move_cmp_pkg::FL_BUSY] = busy_ff;
      end
      move_cmp_pkg::REG_CTRL: rd_mux[move_cmp_pkg::CTRL_ENABLE] = ctrl_en_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff <= psel && penable && !pready_ff;
      if (psel && penable && !pready_ff) begin
        pslverr_ff <= !mapped;
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_ff <= '0;
      ctrl_en_ff <= move_cmp_pkg::CTRL_ENABLE_RST;
    end else if (ce && apb_done && pwrite) begin
      if (paddr == move_cmp_pkg::REG_MASK) begin
        mask_ff <= pwdata[move_cmp_pkg::EV_W-1:0];
      end
      if (paddr == move_cmp_pkg::REG_CTRL) begin
        ctrl_en_ff <= pwdata[move_cmp_pkg::CTRL_ENABLE];
      end
    end
  end

  // a new event wins over the read that clears it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_ff <= '0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      status_ff <= (status_ff & ~ev_clr) | ev_set;
      irq_ff <= |(((status_ff & ~ev_clr) | ev_set) & mask_ff);
    end
  end

  assign instr_busy = busy_ff;
  assign instr_done = done_ff;
  assign instruction_error_flag = err_ff;
  assign greater_flag = gr_ff;
  assign equal_flag = eq_ff;
  assign less_flag = le_ff;
  assign mem = mem_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  logic fin;
  assign fin = ce && state_ff == move_cmp_pkg::ST_FINISH;

  sequence s_skip;
    ce && state_ff == move_cmp_pkg::ST_CHECK && !cond_ff;
  endsequence
  property p_no_exec;
    @(posedge clk) disable iff (!rstn)
    s_skip |=> !mem_ff.req && $stable(err_ff) && $stable(gr_ff)
               ##1 $stable(err_ff) && $stable(gr_ff) && $stable(le_ff);
  endproperty
  a_no_exec: assert property (p_no_exec) else $error("skip wrote");

  property p_cmp_onehot;
    @(posedge clk) disable iff (!rstn)
    fin && cond_ff && !bad && ins_ff.op == move_cmp_pkg::OP_COMPARE
      |=> $onehot({gr_ff, eq_ff, le_ff});
  endproperty
  a_cmp_onehot: assert property (p_cmp_onehot)
    else $error("flags not one-hot");

  property p_cmp_gr;
    @(posedge clk) disable iff (!rstn)
    fin && cond_ff && !bad && ins_ff.op == move_cmp_pkg::OP_COMPARE
      |=> gr_ff == ($past(ins_ff.a) > $past(ins_ff.b)) &&
          le_ff == ($past(ins_ff.a) < $past(ins_ff.b));
  endproperty
  a_cmp_gr: assert property (p_cmp_gr) else $error("wrong compare");

  property p_bit_err;
    @(posedge clk) disable iff (!rstn)
    fin && cond_ff && ins_ff.op == move_cmp_pkg::OP_BIT_MOVE && bad_bit
      |=> err_ff && instr_done;
  endproperty
  a_bit_err: assert property (p_bit_err) else $error("no bit error");

  property p_digit_err;
    @(posedge clk) disable iff (!rstn)
    ce && state_ff == move_cmp_pkg::ST_CHECK && cond_ff &&
      ins_ff.op == move_cmp_pkg::OP_DIGIT_MOVE && bad_digit
      |=> state_ff == move_cmp_pkg::ST_FINISH && !mem_ff.req;
  endproperty
  a_digit_err: assert property (p_digit_err) else $error("digit ran");

  property p_fault;
    @(posedge clk) disable iff (!rstn)
    fin && cond_ff && ins_ff.fault |=> err_ff;
  endproperty
  a_fault: assert property (p_fault) else $error("fault missed");

  property p_bit_write;
    @(posedge clk) disable iff (!rstn)
    ce && state_ff == move_cmp_pkg::ST_RD_DST && mem_ack &&
      ins_ff.op == move_cmp_pkg::OP_BIT_MOVE
      |=> mem_ff.we && mem_ff.wdata[dst_num[3:0]] == ins_ff.a[src_num[3:0]];
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("bit wrong");

  property p_blk_area;
    @(posedge clk) disable iff (!rstn)
    ce && state_ff == move_cmp_pkg::ST_CHECK && cond_ff &&
      ins_ff.op == move_cmp_pkg::OP_BLOCK && bad_block
      |=> !mem_ff.req ##1 err_ff;
  endproperty
  a_blk_area: assert property (p_blk_area) else $error("area ran");

  sequence s_wait;
    mem_ff.req && !mem_ack;
  endsequence
  property p_req_hold;
    @(posedge clk) disable iff (!rstn)
    s_wait |=> mem_ff.req && $stable(mem_ff.addr) && $stable(mem_ff.we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");

  property p_irq;
    @(posedge clk) disable iff (!rstn)
    ce ##1 ce |-> irq_ff == |(status_ff & $past(mask_ff));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
endmodule : move_cmp_unit
`default_nettype wire

// *** mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // memory port
  input wire move_cmp_pkg::mem_req_t mem,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [15:0] ram [128];
  logic [1:0] wait_ff;
  assign mem_ack = mem.req && wait_ff == 2'h0;
  // unanswered bus shows the inverse, never a stale word
  assign mem_rdata = mem_ack ? ram[mem.addr[6:0]] : ~ram[mem.addr[6:0]];
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_ff <= 2'h1;
    end else if (mem_ack) begin
      wait_ff <= 2'($urandom % 3);
      if (mem.we) begin
        ram[mem.addr[6:0]] <= mem.wdata;
      end
    end else if (mem.req) begin
      wait_ff <= wait_ff - 2'h1;
    end
  end
endmodule : mem_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic instr_start = 1'b0;
  move_cmp_pkg::instr_t instr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic busy, done, err_f, gr_f, eq_f, le_f, pready, pslverr, irq, perr;
  move_cmp_pkg::mem_req_t mem;
  logic [15:0] mem_rdata;
  logic mem_ack;
  logic [15:0] sh [128];
  logic xe, xg, xq, xl, en;
  int n_errors = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  move_cmp_unit dut (.clk(clk), .rstn(rstn), .ce(ce),
    .instr_start(instr_start), .instr(instr), .instr_busy(busy),
    .instr_done(done), .instruction_error_flag(err_f),
    .greater_flag(gr_f), .equal_flag(eq_f), .less_flag(le_f),
    .mem(mem), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  mem_model mm (.clk(clk), .rstn(rstn), .mem(mem), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  // ----
  // checking helpers
  // ----
  task summarize;
    $display("errors %0d, checks %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask : chk
  function automatic int val(input logic [7:0] v);
    return v[7:4] * 10 + v[3:0];
  endfunction : val
  function automatic logic ok(input logic [7:0] v);
    return v[3:0] < 10 && v[7:4] < 10 && val(v) < 16;
  endfunction : ok
  function automatic logic [7:0] b2(input int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction : b2
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
           output logic [31:0] rd);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    chk("pready", 1, pready);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task go(input logic [1:0] op, input logic c, input logic [15:0] a, b, d,
          sl, dl, input logic f);
    int n, s, e, t;
    if (c && en) begin
      xe = f;
      if (!f && op == 2'h0) begin
        xe = !ok(b[7:0]) || !ok(b[15:8]);
        if (!xe) sh[d][val(b[15:8])] = a[val(b[7:0])];
      end
      if (!f && op == 2'h1) begin
        xe = b[3:0] > 3 || b[7:4] > 3 || b[11:8] > 3;
        for (int i = 0; i <= b[7:4] && !xe; i++)
          sh[d][4*((b[11:8]+i)%4) +: 4] = a[4*((b[3:0]+i)%4) +: 4];
      end
      if (!f && op == 2'h2) begin
        n = b[15:8];
        s = b[3:0];
        e = b[7:4];
        xe = n > 0 && (a + (s+n-1)/16 > sl || d + (e+n-1)/16 > dl);
        for (int i = 0; i < n && !xe; i++)
          sh[d+(e+i)/16][(e+i)%16] = sh[a+(s+i)/16][(s+i)%16];
      end
      if (!f && op == 2'h3) {xg, xq, xl} = {a > b, a == b, a < b};
    end
    @(posedge clk);
    instr_start <= 1'b1;
    instr <= '{op, c, a, b, d, sl, dl, f};
    @(posedge clk);
    instr_start <= 1'b0;
    ce <= 1'b0;
    repeat (3) @(negedge clk);
    chk("busy", 1, busy);
    chk("done", 0, done);
    @(posedge clk);
    ce <= 1'b1;
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (done !== 1'b1 && t < 6000);
    chk("done", 1, done);
    chk("busy", 0, busy);
    chk("flags", {xe, xg, xq, xl}, {err_f, gr_f, eq_f, le_f});
    for (int i = 0; i < 128; i++) chk("word", sh[i], mm.ram[i]);
  endtask : go
  // ----
  // scenarios
  // ----
  initial begin
    logic [31:0] r;
    void'($urandom(157));
    for (int i = 0; i < 128; i++) begin
      sh[i] = 16'($urandom);
      mm.ram[i] = sh[i];
    end
    {xe, xg, xq, xl} = 4'h0;
    en = 1'b1;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    apb(0, move_cmp_pkg::REG_MASK, 0, r);
    chk("mask", 0, r);
    apb(0, move_cmp_pkg::REG_CTRL, 0, r);
    chk("ctrl", 1, r);
    apb(0, 12'h010, 0, r);
    chk("slverr", 1, perr);
    chk("unmapped", 0, r);
    apb(1, move_cmp_pkg::REG_MASK, 3, r);
    go(3, 1, 16'h1234, 16'h1234, 0, 0, 0, 0);
    apb(0, move_cmp_pkg::REG_FLAGS, 0, r);
    chk("flags reg", 32'h1 << move_cmp_pkg::FL_EQ, r);
    go(3, 1, 16'h0099, 16'h0100, 0, 0, 0, 0);
    repeat (10) go(3, 1, 16'($urandom), 16'($urandom), 0, 0, 0, 0);
    go(3, 0, 16'h0001, 16'h0002, 0, 0, 0, 0);
    repeat (2) @(negedge clk);
    chk("irq", 1, irq);
    apb(0, move_cmp_pkg::REG_STATUS, 0, r);
    chk("status", 1, r);
    repeat (2) @(negedge clk);
    chk("irq", 0, irq);
    go(0, 1, 16'hFFFF, 16'h0016, 5, 0, 0, 0);
    apb(0, move_cmp_pkg::REG_STATUS, 0, r);
    chk("status", 3, r);
    go(0, 1, 16'hFFFF, 16'h0A00, 5, 0, 0, 0);
    go(0, 1, 16'h8000, 16'h0015, 6, 0, 0, 0);
    go(0, 0, 16'h0001, 16'h1500, 6, 0, 0, 0);
    repeat (8) go(0, 1, 16'($urandom), {b2($urandom % 16),
      b2($urandom % 16)}, 7, 0, 0, 0);
    go(1, 1, 16'h1234, 16'h0004, 8, 0, 0, 0);
    go(1, 1, 16'h1234, 16'h0400, 8, 0, 0, 0);
    go(1, 1, 16'hABCD, 16'h0333, 8, 0, 0, 0);
    repeat (8) go(1, 1, 16'($urandom), 16'($urandom) & 16'hF333,
      9, 0, 0, 0);
    go(2, 1, 16'h20, 16'h05ED, 16'h30, 16'h7F, 16'h7F, 0);
    go(2, 1, 16'h40, 16'hFF35, 16'h60, 16'h7F, 16'h7F, 0);
    go(2, 1, 16'h20, 16'h0000, 16'h30, 16'h20, 16'h30, 0);
    go(2, 1, 16'h20, 16'h05ED, 16'h30, 16'h20, 16'h7F, 0);
    go(2, 1, 16'h20, 16'h05ED, 16'h30, 16'h7F, 16'h30, 0);
    go(3, 1, 16'h0009, 16'h0001, 0, 0, 0, 1);
    go(1, 1, 16'h1234, 16'h0000, 8, 0, 0, 1);
    apb(1, move_cmp_pkg::REG_CTRL, 0, r);
    en = 1'b0;
    go(3, 1, 16'h0005, 16'h0001, 0, 0, 0, 0);
    apb(1, move_cmp_pkg::REG_CTRL, 1, r);
    en = 1'b1;
    apb(1, move_cmp_pkg::REG_MASK, 0, r);
    go(3, 1, 16'h0005, 16'h0001, 0, 0, 0, 0);
    repeat (2) @(negedge clk);
    chk("irq", 0, irq);
    summarize();
  end
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
endmodule : tb
`default_nettype wire
